// ===== common/uic_pkg.sv
// Shared constants, encodings and helpers of the serial channel
package uic_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_STATUS = 16'h4120;
  localparam logic [15:0] IDX_TXD = 16'h4121;
  localparam logic [15:0] IDX_RXD = 16'h4122;
  localparam logic [15:0] IDX_MODE = 16'h4123;
  localparam logic [15:0] IDX_CTRL = 16'h4124;
  localparam logic [15:0] IDX_EXP = 16'h4125;
  localparam logic [15:0] IDX_BAUD = 16'h4126;
  localparam logic [15:0] IDX_FINE = 16'h4127;
  localparam logic [15:0] IDX_CLK = 16'h506d;
  // Status bits
  localparam int ST_TX_DONE = 7;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_SECOND = 3;
  localparam int ST_SHIFT = 2;
  localparam int ST_READY = 1;
  localparam int ST_VACANT = 0;
  // Frame format bits
  localparam int MODE_WIDE = 4;
  localparam int MODE_PARITY_ON = 3;
  localparam int MODE_ODD = 2;
  localparam int MODE_TWO_STOP = 1;
  // Control, expansion and clock register bits
  localparam int CTRL_TXDONE_IE = 7;
  localparam int CTRL_RXFAULT_IE = 6;
  localparam int CTRL_RXFULL_IE = 5;
  localparam int CTRL_TXVAC_IE = 4;
  localparam int CTRL_THRESH = 1;
  localparam int CTRL_ENABLE = 0;
  localparam int EXP_IR = 0;
  localparam int CLK_DIV_LO = 4;
  localparam int CLK_SRC_LO = 2;
  localparam int CLK_ON = 0;
  // Writable masks; reserved bits read zero
  localparam logic [7:0] MODE_MASK = 8'h1e;
  localparam logic [7:0] CTRL_MASK = 8'hf3;
  localparam logic [7:0] EXP_MASK = 8'h01;
  localparam logic [7:0] FINE_MASK = 8'h0f;
  localparam logic [7:0] CLK_MASK = 8'h3d;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Bit timing in sample ticks, and last data bit index per width
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [4:0] IR_HOLD = 5'h10;
  localparam logic [2:0] BITS_NARROW = 3'h6;
  localparam logic [2:0] BITS_WIDE = 3'h7;

  typedef enum logic [1:0] {
    UIC_SRC_INT = 2'h0,
    UIC_SRC_LOW = 2'h1,
    UIC_SRC_HIGH = 2'h2,
    UIC_SRC_EXT = 2'h3
  } uic_src_t;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uic_tx_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uic_rx_t;

  function automatic logic [31:0] addr_of(input logic [15:0] idx);
    addr_of = {14'h0000, idx, 2'b00};
  endfunction

  function automatic logic parity_of(input logic [7:0] data,
                                     input logic wide, input logic odd);
    parity_of = (^data[6:0]) ^ (wide & data[7]) ^ odd;
  endfunction
endpackage

// ===== core/uic_baudgen.sv
// Count clock selection, prescaler and fine-adjusted baud counter
module uic_baudgen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] src_ticks,
  input wire logic [1:0] source_sel,
  input wire logic [1:0] prescale_sel,
  input wire logic [7:0] baud_divisor_value,
  input wire logic [3:0] baud_fine_count,
  input wire logic run,
  output logic sample_tick
);
  import uic_pkg::*;

  logic [2:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] uf_q, uf_d;
  logic stretch_q, stretch_d;
  logic tick_q, tick_d;
  logic src_tick, count_tick;
  logic [2:0] pre_mask;

  always_comb begin
    src_tick = src_ticks[source_sel];
    pre_mask = 3'h7 >> (2'h3 - prescale_sel);
    pre_d = pre_q;
    count_tick = 1'b0;
    cnt_d = cnt_q;
    uf_d = uf_q;
    stretch_d = stretch_q;
    tick_d = 1'b0;
    // prescale only on internal or fast sources
    if (source_sel == UIC_SRC_INT || source_sel == UIC_SRC_HIGH) begin
      if (src_tick) begin
        pre_d = 3'((pre_q & pre_mask) == pre_mask ? 3'h0 : pre_q + 3'h1);
        count_tick = (pre_q & pre_mask) == pre_mask;
      end
    end else begin
      count_tick = src_tick;
    end
    if (!run) begin
      pre_d = 3'h0;
      cnt_d = baud_divisor_value;
      uf_d = 4'h0;
      stretch_d = 1'b0;
    end else if (count_tick) begin
      if (cnt_q != 8'h00) begin
        cnt_d = 8'(cnt_q - 8'h01);
      end else if (uf_q < baud_fine_count && !stretch_q) begin
        stretch_d = 1'b1;
      end else begin
        tick_d = 1'b1;
        stretch_d = 1'b0;
        cnt_d = baud_divisor_value;
        uf_d = 4'(uf_q + 4'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 3'h0;
      cnt_q <= 8'h00;
      uf_q <= 4'h0;
      stretch_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      uf_q <= uf_d;
      stretch_q <= stretch_d;
      tick_q <= tick_d;
    end
  end

  assign sample_tick = tick_q;
endmodule

// ===== core/uic_core.sv
// Serial channel with infrared option, APB register slave
// Notes on behaviour
// - Transmission-complete flag sets at end; software clears by writing one.
// - Second-byte flag shows a second received byte is waiting.
// - Transmit-buffer-vacant flag reads one after reset, low while byte waits.
// - Receive-ready flag high while any received byte is buffered.
// - Receive data register returns oldest byte first, then advances.
// - Seven-bit mode uses bits 6..0; eight-bit mode bits 7..0.
// - Transmission-complete request only while its enable is one.
// - Receive-error request only while its enable is one.
// - Receive-full request only while its enable is one.
// - Transmit-vacant request only while its enable is one.
// - Receive buffer counts full after one byte, or two when selected.
// - Fine value inserts that many delays per sixteen underflows.
// - Two-bit prescaler 1/1 to 1/8 for internal or fast source.
module uic_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_oscillator,
  input wire logic low_speed_oscillator,
  input wire logic high_speed_oscillator,
  input wire logic ext_clock_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic irq_tx_done,
  output logic irq_rx_fault,
  output logic irq_rx_full,
  output logic irq_tx_vacant
);
  import uic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge ticks
  logic [4:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= {ext_clock_in, high_speed_oscillator, low_speed_oscillator,
                  internal_oscillator, rxd_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  logic rx_pin;
  logic [3:0] src_ticks;
  assign rx_pin = sync2_q[0];
  assign src_ticks = sync2_q[4:1] & ~prev_q[4:1];

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] mode_q, mode_d, ctrl_q, ctrl_d, exp_q, exp_d;
  logic [7:0] baud_q, baud_d, fine_q, fine_d, clk_q, clk_d;
  logic [7:0] txbuf_q, txbuf_d;
  logic txfull_q, txfull_d, tx_done_q, tx_done_d;
  logic [2:0] err_q, err_d;
  logic [7:0] rx_mem_q [2];
  logic [7:0] rx_mem_d [2];
  logic [1:0] rx_cnt_q, rx_cnt_d;
  logic rx_head_q, rx_head_d;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d;

  logic setup, access, wr, mapped, pop, full, tail;
  logic [7:0] rd_val, status;
  logic enable, wide, par_on, odd, two_stop, infrared;
  // Events from the shifters
  logic tx_load, tx_end, rx_push, rx_ferr, rx_perr;
  logic [7:0] rx_byte;
  logic tx_busy, sample_tick;

  assign enable = ctrl_q[CTRL_ENABLE];
  assign wide = mode_q[MODE_WIDE];
  assign par_on = mode_q[MODE_PARITY_ON];
  assign odd = mode_q[MODE_ODD];
  assign two_stop = mode_q[MODE_TWO_STOP];
  assign infrared = exp_q[EXP_IR];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;

  always_comb begin
    status = {tx_done_q, err_q, rx_cnt_q == 2'h2, tx_busy,
              rx_cnt_q != 2'h0, ~txfull_q};
    mapped = 1'b1;
    rd_val = RST_ZERO;
    unique case (paddr)
      addr_of(IDX_STATUS): rd_val = status;
      addr_of(IDX_TXD): rd_val = txbuf_q;
      addr_of(IDX_RXD): rd_val = rx_cnt_q != 2'h0 ? rx_mem_q[rx_head_q]
                                                  : RST_ZERO;
      addr_of(IDX_MODE): rd_val = mode_q;
      addr_of(IDX_CTRL): rd_val = ctrl_q;
      addr_of(IDX_EXP): rd_val = exp_q;
      addr_of(IDX_BAUD): rd_val = baud_q;
      addr_of(IDX_FINE): rd_val = fine_q;
      addr_of(IDX_CLK): rd_val = clk_q;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    exp_d = exp_q;
    baud_d = baud_q;
    fine_d = fine_q;
    clk_d = clk_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q;
    tx_done_d = tx_done_q;
    err_d = err_q;
    rx_mem_d = rx_mem_q;
    rx_cnt_d = rx_cnt_q;
    rx_head_d = rx_head_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    pop = 1'b0;
    if (tx_load) txfull_d = 1'b0;
    if (setup) begin
      prdata_d = {24'h00_0000, rd_val};
      slverr_d = ~mapped;
    end
    if (wr && mapped) begin
      unique case (paddr)
        addr_of(IDX_STATUS): begin
          if (pwdata[ST_TX_DONE]) tx_done_d = 1'b0;
          err_d = err_q & pwdata[ST_FRAME:ST_OVERRUN];
        end
        addr_of(IDX_TXD): begin
          txbuf_d = wide ? pwdata[7:0] : {1'b0, pwdata[6:0]};
          txfull_d = 1'b1;
        end
        addr_of(IDX_MODE): mode_d = pwdata[7:0] & MODE_MASK;
        addr_of(IDX_CTRL): ctrl_d = pwdata[7:0] & CTRL_MASK;
        addr_of(IDX_EXP): exp_d = pwdata[7:0] & EXP_MASK;
        addr_of(IDX_BAUD): baud_d = pwdata[7:0];
        addr_of(IDX_FINE): fine_d = pwdata[7:0] & FINE_MASK;
        addr_of(IDX_CLK): clk_d = pwdata[7:0] & CLK_MASK;
        default: ;
      endcase
    end
    if (access && !pwrite && paddr == addr_of(IDX_RXD) &&
        rx_cnt_q != 2'h0) begin
      pop = 1'b1;
    end
    // completion sets when nothing is left to send
    if (tx_end && !txfull_q) tx_done_d = 1'b1;
    // two-entry buffer, push at tail and pop at head
    full = rx_cnt_q == 2'h2 && !pop;
    tail = rx_head_q ^ rx_cnt_q[0];
    if (pop) rx_head_d = ~rx_head_q;
    rx_cnt_d = 2'(rx_cnt_q - {1'b0, pop});
    if (rx_push) begin
      // record errors of the new character
      if (rx_ferr) err_d[2] = 1'b1;
      if (rx_perr) err_d[1] = 1'b1;
      if (full) begin
        err_d[0] = 1'b1;
      end else begin
        rx_mem_d[tail] = rx_byte;
        rx_cnt_d = 2'(rx_cnt_d + 2'h1);
      end
    end
    if (!enable) begin
      rx_cnt_d = 2'h0;
      rx_head_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= RST_ZERO;
      ctrl_q <= RST_ZERO;
      exp_q <= RST_ZERO;
      baud_q <= RST_ZERO;
      fine_q <= RST_ZERO;
      clk_q <= RST_ZERO;
      txbuf_q <= RST_ZERO;
      txfull_q <= 1'b0;
      tx_done_q <= 1'b0;
      err_q <= 3'h0;
      rx_mem_q[0] <= RST_ZERO;
      rx_mem_q[1] <= RST_ZERO;
      rx_cnt_q <= 2'h0;
      rx_head_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      exp_q <= exp_d;
      baud_q <= baud_d;
      fine_q <= fine_d;
      clk_q <= clk_d;
      txbuf_q <= txbuf_d;
      txfull_q <= txfull_d;
      tx_done_q <= tx_done_d;
      err_q <= err_d;
      rx_mem_q <= rx_mem_d;
      rx_cnt_q <= rx_cnt_d;
      rx_head_q <= rx_head_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = access;
  assign pslverr = access & slverr_q;
  assign irq_tx_done = ctrl_q[CTRL_TXDONE_IE] & tx_done_q;
  assign irq_rx_fault = ctrl_q[CTRL_RXFAULT_IE] & (|err_q);
  // threshold of one or two bytes
  assign irq_rx_full = ctrl_q[CTRL_RXFULL_IE] &
                       (ctrl_q[CTRL_THRESH] ? rx_cnt_q == 2'h2
                                            : rx_cnt_q != 2'h0);
  assign irq_tx_vacant = ctrl_q[CTRL_TXVAC_IE] & ~txfull_q;

  ////////////////////////////////////////////////////////////////////////
  // Baud generator
  // count clock runs only when enabled
  uic_baudgen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .src_ticks(src_ticks),
    .source_sel(clk_q[CLK_SRC_LO +: 2]),
    .prescale_sel(clk_q[CLK_DIV_LO +: 2]),
    .baud_divisor_value(baud_q),
    .baud_fine_count(fine_q[3:0]),
    .run(clk_q[CLK_ON] & enable),
    .sample_tick(sample_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  uic_tx_t tx_st_q, tx_st_d;
  logic [3:0] tx_tick_q, tx_tick_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic tx_par_q, tx_par_d, tx_stop2_q, tx_stop2_d, txd_q, txd_d, line;
  logic tx_bit_end;

  assign tx_busy = tx_st_q != TX_IDLE;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_tick_d = tx_tick_q;
    tx_idx_d = tx_idx_q;
    tx_sh_d = tx_sh_q;
    tx_par_d = tx_par_q;
    tx_stop2_d = tx_stop2_q;
    tx_load = 1'b0;
    tx_end = 1'b0;
    tx_bit_end = sample_tick && tx_tick_q == TICK_LAST;
    if (sample_tick && tx_busy) tx_tick_d = 4'(tx_tick_q + 4'h1);
    // frame built from the format settings
    unique case (tx_st_q)
      TX_IDLE: begin
        if (txfull_q) begin
          tx_load = 1'b1;
          tx_sh_d = txbuf_q;
          tx_par_d = parity_of(txbuf_q, wide, odd);
          tx_tick_d = 4'h0;
          tx_idx_d = 3'h0;
          tx_stop2_d = 1'b0;
          tx_st_d = TX_START;
        end
      end
      TX_START: if (tx_bit_end) tx_st_d = TX_DATA;
      TX_DATA: begin
        if (tx_bit_end) begin
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_idx_d = 3'(tx_idx_q + 3'h1);
          if (tx_idx_q == (wide ? BITS_WIDE : BITS_NARROW)) begin
            tx_st_d = par_on ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: if (tx_bit_end) tx_st_d = TX_STOP;
      TX_STOP: begin
        if (tx_bit_end) begin
          if (two_stop && !tx_stop2_q) begin
            tx_stop2_d = 1'b1;
          end else begin
            tx_end = 1'b1;
            tx_st_d = TX_IDLE;
          end
        end
      end
    endcase
    // disabled channel holds the shifter idle
    if (!enable) begin
      tx_st_d = TX_IDLE;
      tx_load = 1'b0;
      tx_end = 1'b0;
    end
    unique case (tx_st_d)
      TX_START: line = 1'b0;
      TX_DATA: line = tx_sh_d[0];
      TX_PAR: line = tx_par_d;
      default: line = 1'b1;
    endcase
    // infrared sends a short pulse for each zero
    txd_d = infrared ? (!line && tx_tick_d < IR_PULSE) : line;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_tick_q <= 4'h0;
      tx_idx_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_tick_q <= tx_tick_d;
      tx_idx_q <= tx_idx_d;
      tx_sh_q <= tx_sh_d;
      tx_par_q <= tx_par_d;
      tx_stop2_q <= tx_stop2_d;
      txd_q <= txd_d;
    end
  end
  assign txd_out = txd_q;

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  uic_rx_t rx_st_q, rx_st_d;
  logic [3:0] rx_tick_q, rx_tick_d;
  logic [2:0] rx_idx_q, rx_idx_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [4:0] ir_q, ir_d;
  logic rx_par_q, rx_par_d, rx_line, mid, last;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_tick_d = rx_tick_q;
    rx_idx_d = rx_idx_q;
    rx_sh_d = rx_sh_q;
    rx_par_d = rx_par_q;
    ir_d = ir_q;
    rx_push = 1'b0;
    // seven-bit characters land in bits 6..0
    rx_byte = wide ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
    rx_ferr = 1'b0;
    rx_perr = 1'b0;
    // infrared pulse stretched to a low bit
    if (rx_pin) ir_d = IR_HOLD;
    else if (sample_tick && ir_q != 5'h00) ir_d = 5'(ir_q - 5'h01);
    rx_line = infrared ? ir_q == 5'h00 : rx_pin;
    mid = sample_tick && rx_tick_q == TICK_MID;
    last = sample_tick && rx_tick_q == TICK_LAST;
    if (sample_tick) rx_tick_d = 4'(rx_tick_q + 4'h1);
    unique case (rx_st_q)
      RX_IDLE: begin
        rx_tick_d = 4'h0;
        rx_idx_d = 3'h0;
        if (sample_tick && !rx_line) rx_st_d = RX_START;
      end
      RX_START: begin
        if (mid && rx_line) rx_st_d = RX_IDLE;
        else if (last) rx_st_d = RX_DATA;
      end
      RX_DATA: begin
        if (mid) rx_sh_d = {rx_line, rx_sh_q[7:1]};
        if (last) begin
          rx_idx_d = 3'(rx_idx_q + 3'h1);
          if (rx_idx_q == (wide ? BITS_WIDE : BITS_NARROW)) begin
            rx_st_d = par_on ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (mid) rx_par_d = rx_line;
        if (last) rx_st_d = RX_STOP;
      end
      RX_STOP: begin
        if (mid) begin
          // stop and parity checks on each character
          rx_push = 1'b1;
          rx_ferr = !rx_line;
          rx_perr = par_on && rx_par_q != parity_of(rx_byte, wide, odd);
          rx_st_d = RX_IDLE;
        end
      end
    endcase
    if (!enable) begin
      rx_st_d = RX_IDLE;
      rx_push = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      ir_q <= 5'h00;
    end else begin
      rx_st_q <= rx_st_d;
      rx_tick_q <= rx_tick_d;
      rx_idx_q <= rx_idx_d;
      rx_sh_q <= rx_sh_d;
      rx_par_q <= rx_par_d;
      ir_q <= ir_d;
    end
  end
endmodule

// ===== dv/uic_core_properties.sv
// Checker of bus answers and request gating of the serial channel
module uic_core_checker
  import uic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd_out,
  input wire logic irq_tx_done,
  input wire logic irq_rx_fault,
  input wire logic irq_rx_full,
  input wire logic irq_tx_vacant
);
  logic [7:0] ctl_q, ctl_d, keep;
  logic ir_q, ir_d, acc, wr, hit;
  logic [15:0] idx;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign idx = paddr[17:2];
  assign hit = paddr[1:0] == 2'b00 && paddr[31:18] == 14'h0000 &&
    idx inside {IDX_STATUS, IDX_TXD, IDX_RXD, IDX_MODE, IDX_CTRL,
    IDX_EXP, IDX_BAUD, IDX_FINE, IDX_CLK};
  always_comb begin
    case (idx)
      IDX_MODE: keep = MODE_MASK;
      IDX_CTRL: keep = CTRL_MASK;
      IDX_EXP: keep = EXP_MASK;
      IDX_FINE: keep = FINE_MASK;
      IDX_CLK: keep = CLK_MASK;
      default: keep = 8'hff;
    endcase
  end
  always_comb begin
    ctl_d = ctl_q;
    ir_d = ir_q;
    if (wr && hit && idx == IDX_CTRL)
      ctl_d = pwdata[7:0] & CTRL_MASK;
    if (wr && hit && idx == IDX_EXP)
      ir_d = pwdata[EXP_IR];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
      ir_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      ir_q <= ir_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_ready_a: assert property (pready == acc)
    else $error("pready not tied to access phase");
  bus_error_a: assert property (acc |-> pslverr == !hit)
    else $error("pslverr wrong for address");
  quiet_error_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  unmapped_zero_a: assert property (acc && !pwrite && !hit |->
    prdata == 32'h0000_0000) else $error("unmapped read not zero");
  reserved_zero_a: assert property (acc && !pwrite |->
    prdata[31:8] == 24'h00_0000 && (prdata[7:0] & ~keep) == 8'h00)
    else $error("reserved bits read nonzero");
  done_gate_a: assert property (irq_tx_done |-> ctl_q[CTRL_TXDONE_IE])
    else $error("done request while disabled");
  fault_gate_a: assert property (irq_rx_fault |-> ctl_q[CTRL_RXFAULT_IE])
    else $error("fault request while disabled");
  full_gate_a: assert property (irq_rx_full |-> ctl_q[CTRL_RXFULL_IE])
    else $error("full request while disabled");
  vacant_gate_a: assert property (irq_tx_vacant |-> ctl_q[CTRL_TXVAC_IE])
    else $error("vacant request while disabled");
  idle_line_a: assert property ((!ctl_q[CTRL_ENABLE] && $stable(ir_q)) [*3]
    |-> txd_out == !ir_q) else $error("line not idle while disabled");
endmodule

bind uic_core uic_core_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd_out(txd_out),
  .irq_tx_done(irq_tx_done), .irq_rx_fault(irq_rx_fault),
  .irq_rx_full(irq_rx_full), .irq_tx_vacant(irq_tx_vacant)
);

// ===== dv/uic_remote.sv
// Remote serial transceiver model: frame sender and byte catcher
module uic_remote #(
  parameter int BIT_CYC = 272
) (
  input wire logic pclk,
  input wire logic send,
  input wire logic [7:0] data,
  input wire logic wide,
  input wire logic par_on,
  input wire logic par_bit,
  input wire logic stop_bit,
  input wire logic txd_out,
  output logic rxd_in,
  output logic busy,
  output logic [7:0] caught,
  output int n_caught
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic put(input logic b);
    rxd_in <= b;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
  initial begin
    rxd_in = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (send) begin
        busy <= 1'b1;
        put(1'b0);
        for (int i = 0; i < 8; i++)
          if (i < 7 || wide)
            put(data[i]);
        if (par_on)
          put(par_bit);
        put(stop_bit);
        put(1'b1);
        busy <= 1'b0;
      end
    end
  end
  initial begin
    n_caught = 0;
    caught = 8'h00;
    forever begin
      @(negedge txd_out);
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        caught[i] = txd_out;
        repeat (BIT_CYC) @(posedge pclk);
      end
      n_caught++;
    end
  end
endmodule

// ===== dv/uart_irda_channel_bench.sv
// Self-checking bench of the serial channel
module uart_irda_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, osc, rxd_in, txd_out, er;
  logic pready, pslverr, send, wide, par_on, par_bit, stop_bit, busy;
  logic irq_tx_done, irq_rx_fault, irq_rx_full, irq_tx_vacant;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [7:0] pdata, caught;
  int n_mismatch, samples_checked, cyc, n_caught, n;
  uic_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_oscillator(osc), .low_speed_oscillator(osc),
    .high_speed_oscillator(osc), .ext_clock_in(osc), .rxd_in(rxd_in),
    .txd_out(txd_out), .irq_tx_done(irq_tx_done),
    .irq_rx_fault(irq_rx_fault), .irq_rx_full(irq_rx_full),
    .irq_tx_vacant(irq_tx_vacant));
  uic_remote u_far (.pclk(pclk), .send(send), .data(pdata), .wide(wide),
    .par_on(par_on), .par_bit(par_bit), .stop_bit(stop_bit),
    .txd_out(txd_out), .rxd_in(rxd_in), .busy(busy), .caught(caught),
    .n_caught(n_caught));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    osc = 1'b0;
    forever #20 osc = ~osc;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic par(input logic [7:0] v, input logic odd);
    par = (^v) ^ odd;
  endfunction
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0000, i, 2'b00};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] v);
    apb(1'b1, i, {24'h00_0000, v});
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    apb(1'b0, i, 32'h0000_0000);
    chk($sformatf("register %h", i), e, rd[7:0]);
  endtask
  task automatic frame(input logic [7:0] v, input logic pb,
                       input logic sb);
    pdata <= v;
    par_bit <= pb;
    stop_bit <= sb;
    send <= 1'b1;
    repeat (2) @(posedge pclk);
    send <= 1'b0;
    while (busy !== 1'b0) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] rg [5];
    logic [7:0] mk [5];
    rg = '{IDX_MODE, IDX_CTRL, IDX_BAUD, IDX_FINE, IDX_CLK};
    mk = '{MODE_MASK, CTRL_MASK, 8'hff, FINE_MASK, CLK_MASK};
    {presetn, psel, penable, pwrite, send, par_on, par_bit} = 7'h00;
    {wide, stop_bit} = 2'b11;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pdata = 8'h00;
    seed = 32'd81804;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_STATUS, 8'h01);
    rdc(IDX_RXD, 8'h00);
    foreach (rg[i]) begin
      seed = lfsr(seed);
      rdc(rg[i], 8'h00);
      wr(rg[i], seed[7:0]);
      rdc(rg[i], seed[7:0] & mk[i]);
      wr(rg[i], 8'h00);
    end
    apb(1'b1, 16'h0001, 32'hffff_ffff);
    apb(1'b0, 16'h0001, 32'h0000_0000);
    chk("unmapped data", 8'h00, rd[7:0]);
    chk("unmapped error", 8'h01, {7'h00, er});
    wr(IDX_CLK, 8'h11);
    wr(IDX_FINE, 8'h01);
    wr(IDX_MODE, 8'h10);
    wr(IDX_CTRL, 8'h11);
    @(posedge pclk);
    chk("irq_tx_vacant", 8'h01, {7'h00, irq_tx_vacant});
    wr(IDX_CTRL, 8'h81);
    @(posedge pclk);
    chk("irq_tx_vacant", 8'h00, {7'h00, irq_tx_vacant});
    seed = lfsr(seed);
    n = n_caught;
    wr(IDX_TXD, seed[7:0]);
    while (n_caught == n) @(posedge pclk);
    chk("serial out", seed[7:0], caught);
    rd = 32'h0000_0000;
    for (int k = 0; k < 100 && rd[7] !== 1'b1; k++)
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
    chk("status", 8'h81, rd[7:0]);
    chk("irq_tx_done", 8'h01, {7'h00, irq_tx_done});
    wr(IDX_STATUS, 8'h7f);
    rdc(IDX_STATUS, 8'h81);
    wr(IDX_STATUS, 8'h80);
    rdc(IDX_STATUS, 8'h01);
    wr(IDX_CTRL, 8'h23);
    seed = lfsr(seed);
    frame(seed[7:0], 1'b0, 1'b1);
    rdc(IDX_STATUS, 8'h03);
    chk("irq_rx_full", 8'h00, {7'h00, irq_rx_full});
    frame(seed[15:8], 1'b0, 1'b1);
    rdc(IDX_STATUS, 8'h0b);
    chk("irq_rx_full", 8'h01, {7'h00, irq_rx_full});
    rdc(IDX_RXD, seed[7:0]);
    rdc(IDX_STATUS, 8'h03);
    rdc(IDX_RXD, seed[15:8]);
    rdc(IDX_STATUS, 8'h01);
    wr(IDX_MODE, 8'h00);
    wide <= 1'b0;
    seed = lfsr(seed);
    frame(seed[7:0], 1'b0, 1'b1);
    rdc(IDX_RXD, {1'b0, seed[6:0]});
    wide <= 1'b1;
    par_on <= 1'b1;
    wr(IDX_CTRL, 8'h41);
    for (int o = 0; o < 2; o++) begin
      wr(IDX_MODE, o[0] ? 8'h1c : 8'h18);
      seed = lfsr(seed);
      frame(seed[7:0], par(seed[7:0], o[0]), 1'b1);
      rdc(IDX_RXD, seed[7:0]);
      frame(seed[7:0], !par(seed[7:0], o[0]), 1'b1);
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
      chk("status", 8'h20, rd[7:0] & 8'hf0);
      chk("irq_rx_fault", 8'h01, {7'h00, irq_rx_fault});
      wr(IDX_STATUS, 8'h00);
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
      chk("status", 8'h00, rd[7:0] & 8'hf0);
      apb(1'b0, IDX_RXD, 32'h0000_0000);
    end
    par_on <= 1'b0;
    wr(IDX_MODE, 8'h10);
    frame(8'h55, 1'b0, 1'b0);
    apb(1'b0, IDX_STATUS, 32'h0000_0000);
    chk("status", 8'h40, rd[7:0] & 8'hf0);
    chk("irq_rx_fault", 8'h01, {7'h00, irq_rx_fault});
    wr(IDX_CTRL, 8'h01);
    @(posedge pclk);
    chk("irq_rx_fault", 8'h00, {7'h00, irq_rx_fault});
    print_verdict();
  end
endmodule
